//--- rtl/remap_pkg.sv
/*
 * Constants for the output pin remap register block: register offsets,
 * field positions, reset values and widths.
 * Assumes a 16-bit register port with fixed word offsets.
 */
// How it works
// - Seventeen remap registers: nine input, eight output.
// - Remap contents change only while lock is clear.
// - Register 11 bits 12-8 select pin 23.
// - Register 11 bits 4-0 select pin 22.
// - Register 12 bits 12-8 select pin 25.
// - Register 12 bits 4-0 select pin 24.
// - Bits 15-13 and 7-5 read zero, ignore writes.
// - Selector bits read/write, zero after reset.
package remap_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned SEL_W = 5;
    localparam int unsigned PIN_N = 4;
    localparam int unsigned FUNC_N = 32;
    localparam int unsigned IN_REG_N = 9;
    localparam int unsigned OUT_REG_N = 8;
    localparam logic [ADDR_W-1:0] OUT_REMAP_22_23_OFS = 12'h6d6;
    localparam logic [ADDR_W-1:0] OUT_REMAP_24_25_OFS = 12'h6d8;
    localparam int unsigned LO_SEL_LSB = 0;
    localparam int unsigned HI_SEL_LSB = 8;
    localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;
    localparam logic [SEL_W-1:0] SEL_PORT = 5'h00;
    localparam logic [DATA_W-1:0] READ_UNMAPPED = 16'h0000;
endpackage

//--- rtl/sel_if.sv
/*
 * Interface carrying the four pin selectors from the register file
 * to the routing module.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/1ps
interface sel_if;
    logic [remap_pkg::SEL_W-1:0] sel [remap_pkg::PIN_N];
    modport regs (output sel);
    modport route (input sel);
endinterface

//--- rtl/pin_route.sv
/*
 * Per-pin output multiplexer: picks a peripheral function output or the
 * ordinary port latch depending on the selector.
 * Assumes function outputs are on the same clock as the selectors.
 */
`timescale 1ns/1ps
module pin_route (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    sel_if.route sel_in,
    input wire logic [remap_pkg::FUNC_N-1:0] func_out,
    input wire logic [remap_pkg::FUNC_N-1:0] func_oe,
    input wire logic [remap_pkg::PIN_N-1:0] port_out,
    input wire logic [remap_pkg::PIN_N-1:0] port_oe,
    output logic [remap_pkg::PIN_N-1:0] pin_out_ff,
    output logic [remap_pkg::PIN_N-1:0] pin_oe_ff
);
    genvar i;
    generate
        for (i = 0; i < remap_pkg::PIN_N; i++) begin : g_pin
            always_ff @(posedge clk) begin
                if (reset) begin
                    pin_out_ff[i] <= 1'b0;
                    pin_oe_ff[i] <= 1'b0;
                end else if (clk_en) begin
                    if (sel_in.sel[i] == remap_pkg::SEL_PORT) begin
                        pin_out_ff[i] <= port_out[i];
                        pin_oe_ff[i] <= port_oe[i];
                    end else begin
                        pin_out_ff[i] <= func_out[sel_in.sel[i]];
                        pin_oe_ff[i] <= func_oe[sel_in.sel[i]];
                    end
                end
            end
            a_route_port: assert property (@(posedge clk) disable iff (reset)
                clk_en && sel_in.sel[i] == remap_pkg::SEL_PORT
                |=> pin_out_ff[i] == $past(port_out[i]))
                else $error("port value not routed for zero selector");
            a_route_func: assert property (@(posedge clk) disable iff (reset)
                clk_en && sel_in.sel[i] != remap_pkg::SEL_PORT
                |=> pin_oe_ff[i] == $past(func_oe[sel_in.sel[i]]))
                else $error("function enable not routed");
        end
    endgenerate
endmodule

//--- rtl/output_pin_remap_regs.sv
/*
 * Output remap registers for remappable pins 22 to 25, with lock gating
 * and pin routing.
 * Assumes remap_lock comes from oscillator control logic on clk; the
 * other fifteen remap registers live elsewhere.
 */
`timescale 1ns/1ps
module output_pin_remap_regs (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [remap_pkg::ADDR_W-1:0] addr,
    input wire logic [remap_pkg::DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [remap_pkg::DATA_W-1:0] rdata_ff,
    input wire logic remap_lock,
    input wire logic [remap_pkg::FUNC_N-1:0] func_out,
    input wire logic [remap_pkg::FUNC_N-1:0] func_oe,
    input wire logic [remap_pkg::PIN_N-1:0] port_out,
    input wire logic [remap_pkg::PIN_N-1:0] port_oe,
    output logic [remap_pkg::PIN_N-1:0] pin_out_ff,
    output logic [remap_pkg::PIN_N-1:0] pin_oe_ff
);
    logic [remap_pkg::SEL_W-1:0] pin_twentytwo_function_sel_ff;
    logic [remap_pkg::SEL_W-1:0] pin_twentythree_function_sel_ff;
    logic [remap_pkg::SEL_W-1:0] pin_twentyfour_function_sel_ff;
    logic [remap_pkg::SEL_W-1:0] pin_twentyfive_function_sel_ff;
    logic wr_ok;
    logic hit_22_23;
    logic hit_24_25;
    logic [remap_pkg::DATA_W-1:0] nxt_rdata;
    sel_if sel_bus ();

    // Only output registers 11 and 12 decode here; the rest live elsewhere
    assign hit_22_23 = (addr == remap_pkg::OUT_REMAP_22_23_OFS);
    assign hit_24_25 = (addr == remap_pkg::OUT_REMAP_24_25_OFS);
    // Lock is a same-clock level; a set lock drops the write silently
    assign wr_ok = wr_stb && !remap_lock;

    always_ff @(posedge clk) begin
        if (reset) begin
            pin_twentytwo_function_sel_ff <= remap_pkg::SEL_RESET;
            pin_twentythree_function_sel_ff <= remap_pkg::SEL_RESET;
        end else if (clk_en && wr_ok && hit_22_23) begin
            pin_twentytwo_function_sel_ff <= wdata[remap_pkg::LO_SEL_LSB +:
                remap_pkg::SEL_W];
            pin_twentythree_function_sel_ff <= wdata[remap_pkg::HI_SEL_LSB +:
                remap_pkg::SEL_W];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pin_twentyfour_function_sel_ff <= remap_pkg::SEL_RESET;
            pin_twentyfive_function_sel_ff <= remap_pkg::SEL_RESET;
        end else if (clk_en && wr_ok && hit_24_25) begin
            pin_twentyfour_function_sel_ff <= wdata[remap_pkg::LO_SEL_LSB +:
                remap_pkg::SEL_W];
            pin_twentyfive_function_sel_ff <= wdata[remap_pkg::HI_SEL_LSB +:
                remap_pkg::SEL_W];
        end
    end

    // Unimplemented bits are simply never stored, so they read zero
    always_comb begin
        nxt_rdata = remap_pkg::READ_UNMAPPED;
        if (hit_22_23) begin
            nxt_rdata[remap_pkg::LO_SEL_LSB +: remap_pkg::SEL_W] =
                pin_twentytwo_function_sel_ff;
            nxt_rdata[remap_pkg::HI_SEL_LSB +: remap_pkg::SEL_W] =
                pin_twentythree_function_sel_ff;
        end else if (hit_24_25) begin
            nxt_rdata[remap_pkg::LO_SEL_LSB +: remap_pkg::SEL_W] =
                pin_twentyfour_function_sel_ff;
            nxt_rdata[remap_pkg::HI_SEL_LSB +: remap_pkg::SEL_W] =
                pin_twentyfive_function_sel_ff;
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_ff <= remap_pkg::READ_UNMAPPED;
        end else if (clk_en) begin
            rdata_ff <= rd_stb ? nxt_rdata : remap_pkg::READ_UNMAPPED;
        end
    end

    assign sel_bus.sel[0] = pin_twentytwo_function_sel_ff;
    assign sel_bus.sel[1] = pin_twentythree_function_sel_ff;
    assign sel_bus.sel[2] = pin_twentyfour_function_sel_ff;
    assign sel_bus.sel[3] = pin_twentyfive_function_sel_ff;

    pin_route u_route (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .sel_in(sel_bus.route),
        .func_out(func_out),
        .func_oe(func_oe),
        .port_out(port_out),
        .port_oe(port_oe),
        .pin_out_ff(pin_out_ff),
        .pin_oe_ff(pin_oe_ff)
    );

    a_lock_holds: assert property (@(posedge clk) disable iff (reset)
        remap_lock && wr_stb |=> $stable(pin_twentytwo_function_sel_ff)
        && $stable(pin_twentyfive_function_sel_ff))
        else $error("selector changed while locked");
    a_lock_clear_wr: assert property (@(posedge clk) disable iff (reset)
        !remap_lock && wr_stb && clk_en && hit_22_23
        |=> pin_twentythree_function_sel_ff == $past(wdata[12:8]))
        else $error("unlocked write not taken");
    a_sel_23_field: assert property (@(posedge clk) disable iff (reset)
        rd_stb && clk_en && hit_22_23 |=>
        rdata_ff[12:8] == $past(pin_twentythree_function_sel_ff))
        else $error("pin 23 field misplaced");
    a_sel_22_field: assert property (@(posedge clk) disable iff (reset)
        wr_ok && clk_en && hit_22_23
        |=> pin_twentytwo_function_sel_ff == $past(wdata[4:0]))
        else $error("pin 22 field misplaced");
    a_sel_25_field: assert property (@(posedge clk) disable iff (reset)
        wr_ok && clk_en && hit_24_25
        |=> pin_twentyfive_function_sel_ff == $past(wdata[12:8]))
        else $error("pin 25 field misplaced");
    a_sel_24_field: assert property (@(posedge clk) disable iff (reset)
        wr_ok && clk_en && hit_24_25 ##1 rd_stb && clk_en && hit_24_25
        |=> rdata_ff[4:0] == $past(wdata[4:0], 2))
        else $error("pin 24 readback wrong");
    a_unused_zero: assert property (@(posedge clk) disable iff (reset)
        rdata_ff[15:13] == 3'h0 && rdata_ff[7:5] == 3'h0)
        else $error("unimplemented bits not zero");
    a_reset_zero: assert property (@(posedge clk)
        $past(reset) |-> pin_twentyfour_function_sel_ff == 5'h00
        && rdata_ff == 16'h0000)
        else $error("reset value not zero");

    // Every selector clears on reset, whatever the clock enable does
    a_reset_sel_22: assert property (@(posedge clk)
        $past(reset) |-> pin_twentytwo_function_sel_ff == 5'h00)
        else $error("pin 22 selector not zero after reset");

    a_reset_sel_23: assert property (@(posedge clk)
        $past(reset) |-> pin_twentythree_function_sel_ff == 5'h00)
        else $error("pin 23 selector not zero after reset");

    a_reset_sel_25: assert property (@(posedge clk)
        $past(reset) |-> pin_twentyfive_function_sel_ff == 5'h00)
        else $error("pin 25 selector not zero after reset");

    a_reset_pin_out: assert property (@(posedge clk)
        $past(reset) |-> pin_out_ff == 4'h0)
        else $error("pin levels not zero after reset");

    a_reset_pin_oe: assert property (@(posedge clk)
        $past(reset) |-> pin_oe_ff == 4'h0)
        else $error("pin enables not zero after reset");

    // Lock must hold each selector on its own, not just the pair checked
    a_lock_hold_22: assert property (@(posedge clk) disable iff (reset)
        remap_lock && wr_stb
        |=> $stable(pin_twentytwo_function_sel_ff))
        else $error("pin 22 selector changed while locked");

    a_lock_hold_23: assert property (@(posedge clk) disable iff (reset)
        remap_lock && wr_stb
        |=> $stable(pin_twentythree_function_sel_ff))
        else $error("pin 23 selector changed while locked");

    a_lock_hold_24: assert property (@(posedge clk) disable iff (reset)
        remap_lock && wr_stb
        |=> $stable(pin_twentyfour_function_sel_ff))
        else $error("pin 24 selector changed while locked");

    a_lock_hold_25: assert property (@(posedge clk) disable iff (reset)
        remap_lock && wr_stb
        |=> $stable(pin_twentyfive_function_sel_ff))
        else $error("pin 25 selector changed while locked");

    a_sel_24_write: assert property (@(posedge clk) disable iff (reset)
        wr_ok && clk_en && hit_24_25
        |=> pin_twentyfour_function_sel_ff == $past(wdata[4:0]))
        else $error("pin 24 write not taken");

    // A write to the other register must not disturb this pair
    a_miss_keep_lo: assert property (@(posedge clk) disable iff (reset)
        wr_stb && !hit_22_23 |=> $stable(pin_twentytwo_function_sel_ff)
        && $stable(pin_twentythree_function_sel_ff))
        else $error("pins 22/23 changed by foreign write");

    a_miss_keep_hi: assert property (@(posedge clk) disable iff (reset)
        wr_stb && !hit_24_25 |=> $stable(pin_twentyfour_function_sel_ff)
        && $stable(pin_twentyfive_function_sel_ff))
        else $error("pins 24/25 changed by foreign write");

    a_rd_no_write: assert property (@(posedge clk) disable iff (reset)
        !wr_stb |=> $stable(pin_twentytwo_function_sel_ff)
        && $stable(pin_twentythree_function_sel_ff)
        && $stable(pin_twentyfour_function_sel_ff)
        && $stable(pin_twentyfive_function_sel_ff))
        else $error("selector changed without a write");

    // Low clock enable freezes every piece of state
    a_freeze_sel_22: assert property (@(posedge clk) disable iff (reset)
        !clk_en |=> $stable(pin_twentytwo_function_sel_ff))
        else $error("pin 22 selector moved with enable low");

    a_freeze_sel_23: assert property (@(posedge clk) disable iff (reset)
        !clk_en |=> $stable(pin_twentythree_function_sel_ff))
        else $error("pin 23 selector moved with enable low");

    a_freeze_sel_24: assert property (@(posedge clk) disable iff (reset)
        !clk_en |=> $stable(pin_twentyfour_function_sel_ff))
        else $error("pin 24 selector moved with enable low");

    a_freeze_sel_25: assert property (@(posedge clk) disable iff (reset)
        !clk_en |=> $stable(pin_twentyfive_function_sel_ff))
        else $error("pin 25 selector moved with enable low");

    a_freeze_rdata: assert property (@(posedge clk) disable iff (reset)
        !clk_en |=> $stable(rdata_ff))
        else $error("read data moved with enable low");

    a_freeze_pin_out: assert property (@(posedge clk) disable iff (reset)
        !clk_en |=> $stable(pin_out_ff))
        else $error("pin levels moved with enable low");

    a_freeze_pin_oe: assert property (@(posedge clk) disable iff (reset)
        !clk_en |=> $stable(pin_oe_ff))
        else $error("pin enables moved with enable low");

    // Readback of every field, not only the pin 23 one
    a_rd_sel_22: assert property (@(posedge clk) disable iff (reset)
        rd_stb && clk_en && hit_22_23
        |=> rdata_ff[4:0] == $past(pin_twentytwo_function_sel_ff))
        else $error("pin 22 readback wrong");

    a_rd_sel_24: assert property (@(posedge clk) disable iff (reset)
        rd_stb && clk_en && hit_24_25
        |=> rdata_ff[4:0] == $past(pin_twentyfour_function_sel_ff))
        else $error("pin 24 field misplaced");

    a_rd_sel_25: assert property (@(posedge clk) disable iff (reset)
        rd_stb && clk_en && hit_24_25
        |=> rdata_ff[12:8] == $past(pin_twentyfive_function_sel_ff))
        else $error("pin 25 readback wrong");

    a_rd_unmapped: assert property (@(posedge clk) disable iff (reset)
        rd_stb && clk_en && !hit_22_23 && !hit_24_25
        |=> rdata_ff == remap_pkg::READ_UNMAPPED)
        else $error("unmapped read not zero");

    // Read data stand for one cycle only; otherwise the bus idles at zero
    a_rd_idle_zero: assert property (@(posedge clk) disable iff (reset)
        clk_en && !rd_stb |=> rdata_ff == remap_pkg::READ_UNMAPPED)
        else $error("read data outside read cycle");

    // Each pin follows its own named selector register
    a_pin_22_route: assert property (@(posedge clk) disable iff (reset)
        clk_en |=> pin_out_ff[0] == $past(
        pin_twentytwo_function_sel_ff == remap_pkg::SEL_PORT ?
        port_out[0] : func_out[pin_twentytwo_function_sel_ff]))
        else $error("pin 22 level misrouted");

    a_pin_23_route: assert property (@(posedge clk) disable iff (reset)
        clk_en |=> pin_out_ff[1] == $past(
        pin_twentythree_function_sel_ff == remap_pkg::SEL_PORT ?
        port_out[1] : func_out[pin_twentythree_function_sel_ff]))
        else $error("pin 23 level misrouted");

    a_pin_24_route: assert property (@(posedge clk) disable iff (reset)
        clk_en |=> pin_oe_ff[2] == $past(
        pin_twentyfour_function_sel_ff == remap_pkg::SEL_PORT ?
        port_oe[2] : func_oe[pin_twentyfour_function_sel_ff]))
        else $error("pin 24 enable misrouted");

    a_pin_25_route: assert property (@(posedge clk) disable iff (reset)
        clk_en |=> pin_oe_ff[3] == $past(
        pin_twentyfive_function_sel_ff == remap_pkg::SEL_PORT ?
        port_oe[3] : func_oe[pin_twentyfive_function_sel_ff]))
        else $error("pin 25 enable misrouted");
endmodule

//--- verif/periph_func_model.sv
/*
 * Model of the peripheral function outputs that the remap block routes.
 * Assumes the remap block samples these levels on its own clock; they
 * are fixed, so each routed pin has a known expected level.
 */
`timescale 1ns/1ps
module periph_func_model #(
    parameter logic [31:0] OUT_PAT = 32'h5a3c_96e1
) (
    output logic [remap_pkg::FUNC_N-1:0] func_out,
    output logic [remap_pkg::FUNC_N-1:0] func_oe
);
    // Enables differ from levels for functions 0-19 and 24-27 so a swapped mux input shows up there
    assign func_out = OUT_PAT;
    assign func_oe = OUT_PAT ^ 32'h0f0f_ffff;
endmodule

//--- verif/output_pin_remap_regs_test.sv
/*
 * Bench for the output remap registers: reads, writes, lock gating and
 * pin routing. Assumes the function model drives fixed levels.
 */
`timescale 1ns/1ps
module output_pin_remap_regs_test;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic [11:0] addr = 12'h000;
    logic [15:0] wdata = 16'h0000;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic remap_lock = 1'b0;
    logic [3:0] port_out = 4'ha;
    logic [3:0] port_oe = 4'h6;
    logic [15:0] rdata_ff;
    logic [3:0] pin_out_ff;
    logic [3:0] pin_oe_ff;
    logic [31:0] func_out;
    logic [31:0] func_oe;
    logic [4:0] sel [4] = '{default: 5'h00};
    int bad_count = 0;
    int tests_run = 0;

    always #12.5 clk = ~clk;

    periph_func_model model_u (.func_out(func_out), .func_oe(func_oe));

    output_pin_remap_regs dut_u (
        .clk(clk), .reset(reset), .clk_en(clk_en), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata_ff(rdata_ff), .remap_lock(remap_lock),
        .func_out(func_out), .func_oe(func_oe), .port_out(port_out),
        .port_oe(port_oe), .pin_out_ff(pin_out_ff), .pin_oe_ff(pin_oe_ff)
    );

    task automatic chk_reg(input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic chk_pin(input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 chk_reg(exp, rdata_ff);
    endtask

    task automatic pins();
        logic [3:0] eo;
        logic [3:0] ee;
        repeat (2) @(posedge clk);
        #1;
        for (int i = 0; i < 4; i++) begin
            eo[i] = (sel[i] == 5'h00) ? port_out[i] : func_out[sel[i]];
            ee[i] = (sel[i] == 5'h00) ? port_oe[i] : func_oe[sel[i]];
        end
        chk_pin({ee, eo}, {pin_oe_ff, pin_out_ff});
    endtask

    task automatic finish_test();
        $display("Counts: %0d checks, %0d mismatches", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        rd(12'h6d6, 16'h0000);
        rd(12'h6d8, 16'h0000);
        rd(12'h6d4, 16'h0000);
        pins();
        $display("test reset_values done");
        wr(12'h6d6, 16'hffff);
        wr(12'h6d8, 16'h1a05);
        wr(12'h6d4, 16'h1234);
        rd(12'h6d6, 16'h1f1f);
        rd(12'h6d8, 16'h1a05);
        rd(12'h6d4, 16'h0000);
        sel = '{5'h1f, 5'h1f, 5'h05, 5'h1a};
        pins();
        $display("test field_write done");
        @(posedge clk);
        remap_lock <= 1'b1;
        wr(12'h6d6, 16'h0000);
        wr(12'h6d8, 16'h0000);
        rd(12'h6d6, 16'h1f1f);
        rd(12'h6d8, 16'h1a05);
        pins();
        @(posedge clk);
        remap_lock <= 1'b0;
        wr(12'h6d6, 16'h0300);
        rd(12'h6d6, 16'h0300);
        sel[0] = 5'h00;
        sel[1] = 5'h03;
        pins();
        $display("test lock_gating done");
        @(posedge clk);
        clk_en <= 1'b0;
        wr(12'h6d6, 16'h1f1f);
        clk_en <= 1'b1;
        rd(12'h6d6, 16'h0300);
        pins();
        $display("test clock_enable done");
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(12'h6d6, 16'h0000);
        rd(12'h6d8, 16'h0000);
        sel = '{default: 5'h00};
        pins();
        $display("test mid_reset done");
        finish_test();
    end

    // Whole run is about 60 cycles; this leaves wide margin
    initial begin
        #20000;
        bad_count++;
        finish_test();
    end
endmodule
